// [spg_pkg.sv]
package spg_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] RIGHT_ALT_GAIN_ADDR  = 8'h10; // Right alternative gain register.
  localparam logic [7:0] LEFT_ALT_GAIN_ADDR   = 8'h11; // Left alternative gain register.
  localparam logic [7:0] SYSTEM_CONTROL_ADDR  = 8'h20; // System control register.
  localparam logic [7:0] POWER_STATUS_ADDR    = 8'h21; // Power status register.
  localparam logic [7:0] PRIMARY_RIGHT_ADDR   = 8'h30; // Primary right gain register (outside).
  localparam logic [7:0] PRIMARY_LEFT_ADDR    = 8'h31; // Primary left gain register (outside).
  localparam logic [7:0] EVAL_FIRST_ADDR      = 8'h3D; // First evaluation register.
  localparam logic [7:0] EVAL_LAST_ADDR       = 8'h3F; // Last evaluation register.

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int         REVISION_MSB         = 7;     // Revision field top bit.
  localparam int         REVISION_LSB         = 4;     // Revision field bottom bit.
  localparam int         EVAL_UNLOCK_BIT      = 3;     // Evaluation write unlock bit.
  localparam int         KEEPALIVE_BIT        = 0;     // Power keepalive bit.
  localparam int         ALT_SELECT_BIT       = 7;     // Alternate gain select bit.
  localparam int         TEST_BIT             = 7;     // Read-only test bit.
  localparam int         GAIN_MSB             = 5;     // Gain code top bit.
  localparam logic [5:0] GAIN_MUTE            = 6'h00; // Gain code that mutes.
  localparam logic [7:0] RIGHT_ALT_RESET      = 8'h80; // Right alternative gain reset.
  localparam logic [7:0] LEFT_ALT_RESET       = 8'h00; // Left alternative gain reset.
  localparam logic       KEEPALIVE_RESET      = 1'b1;  // Keepalive set at power on.
  localparam logic       EVAL_UNLOCK_RESET    = 1'b0;  // Evaluation writes locked at reset.

  // ****************************************************************
  // Carriers
  // ****************************************************************
  // Block power states that feed the status register.
  typedef struct packed {
    logic brownout_flag;          // Supply at brown-out level.
    logic headphone_amp_powered;  // Headphone amplifier on.
    logic preamp_powered;         // Microphone preamplifier on.
    logic mic_pump_running;       // Microphone charge pump on.
    logic mic_supply_powered;     // Microphone supply on.
  } spg_block_status_t;

  // Gain pair handed to the microphone path.
  typedef struct packed {
    logic       muted_right;      // Right channel muted.
    logic       muted_left;       // Left channel muted.
    logic [5:0] right_code;       // Right gain code.
    logic [5:0] left_code;        // Left gain code.
  } spg_gain_pair_t;

endpackage

// [spg_startup_seq.sv]
`timescale 1ns/10ps
// Startup sequencer that picks and loads the microphone gain set.
module spg_startup_seq
(
  input  wire logic                  clock_in,          // System clock.
  input  wire logic                  rst_n_in,          // Asynchronous reset, active low.
  input  wire logic                  start_in,          // Begin a power-up sequence.
  input  wire logic                  alt_select_in,     // Use alternative gain set.
  input  wire logic [5:0]            alt_right_in,      // Alternative right code.
  input  wire logic [5:0]            alt_left_in,       // Alternative left code.
  input  wire logic [5:0]            pri_right_in,      // Primary right code.
  input  wire logic [5:0]            pri_left_in,       // Primary left code.
  output spg_pkg::spg_gain_pair_t    gain_out,          // Loaded gain pair.
  output logic                       done_out           // Sequence has completed.
);

  // ****************************************************************
  // State machine
  // ****************************************************************
  typedef enum logic [1:0] {
    SPG_IDLE = 2'b00,   // Waiting for a start.
    SPG_LOAD = 2'b01,   // Loading the chosen gain set.
    SPG_DONE = 2'b11    // Sequence finished.
  } spg_seq_state_t;

  spg_seq_state_t          state_reg;   // Current state.
  spg_seq_state_t          state_next;  // Next state.
  spg_pkg::spg_gain_pair_t gain_reg;    // Loaded gains.
  spg_pkg::spg_gain_pair_t gain_next;   // Next loaded gains.

  // Computes the next state and gain pair.
  always_comb
  begin
    state_next = state_reg;
    gain_next  = gain_reg;
    unique case (state_reg)
      SPG_IDLE:
      begin
        // Wait here until the device is powered up.
        if (start_in)
        begin
          state_next = SPG_LOAD;
        end
      end
      SPG_LOAD:
      begin
        // The select bit decides which set is loaded.
        if (alt_select_in)
        begin
          gain_next.right_code = alt_right_in;
          gain_next.left_code  = alt_left_in;
        end
        else
        begin
          gain_next.right_code = pri_right_in;
          gain_next.left_code  = pri_left_in;
        end
        gain_next.muted_right = (gain_next.right_code == spg_pkg::GAIN_MUTE);
        gain_next.muted_left  = (gain_next.left_code == spg_pkg::GAIN_MUTE);
        state_next = SPG_DONE;
      end
      SPG_DONE:
      begin
        // Drop back when power is released so the next wake reloads.
        if (!start_in)
        begin
          state_next = SPG_IDLE;
        end
      end
      default:
      begin
        state_next = SPG_IDLE;
      end
    endcase
  end

  // Registers the sequencer state.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= SPG_IDLE;
      gain_reg  <= '0;
    end
    else
    begin
      state_reg <= state_next;
      gain_reg  <= gain_next;
    end
  end

  assign gain_out = gain_reg;
  assign done_out = (state_reg == SPG_DONE);

endmodule // spg_startup_seq

// [spg_regs.sv]
`timescale 1ns/10ps
// Summary of operation
// - Control register bits 7:4 show revision.
// - Control bit 3 unlocks evaluation register writes.
// - Clearing keepalive powers down; set after power-on.
// - I2C start condition wakes device after power-down.
// - Status bit 5 shows sequencer completion.
// - Status bit 6 shows brown-out.
// - Status bit 4 shows headphone amplifier power.
// - Status bit 3 shows preamplifier power.
// - Status bit 1 shows charge pump running.
// - Status bit 0 shows microphone supply.
// - Right gain: zero mutes, 0.5 dB steps.
// - Left gain uses same six-bit encoding.
// - Alternate select overrides primary gain registers.
// - Startup sequencer reads select to pick gains.
module spg_regs
#(
  parameter logic [3:0] REVISION = 4'h2      // Silicon revision, arbitrary value.
)
(
  input  wire logic                     clock_in,       // System clock.
  input  wire logic                     rst_n_in,       // Asynchronous reset, active low.
  input  wire logic                     wr_en_in,       // Register write strobe.
  input  wire logic                     rd_en_in,       // Register read strobe.
  input  wire logic [7:0]               addr_in,        // Register address.
  input  wire logic [7:0]               wdata_in,       // Write data.
  input  wire logic                     i2c_start_in,   // I2C start condition seen.
  input  wire logic [5:0]               pri_right_in,   // Primary right gain code.
  input  wire logic [5:0]               pri_left_in,    // Primary left gain code.
  input  spg_pkg::spg_block_status_t    status_in,      // Live block states.
  output logic [7:0]                    rdata_out,      // Read data.
  output logic                          rvalid_out,     // Read data valid.
  output logic                          eval_wr_en_out, // Write to evaluation registers.
  output logic                          powered_out,    // Chip held powered.
  output spg_pkg::spg_gain_pair_t       gain_out,       // Active gain pair.
  output logic                          seq_done_out    // Power-up sequence done.
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Tells whether an address falls in the evaluation register range.
  function automatic logic is_eval(input logic [7:0] a);
    is_eval = (a >= spg_pkg::EVAL_FIRST_ADDR) && (a <= spg_pkg::EVAL_LAST_ADDR);
  endfunction

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [5:0] right_alt_gain_code_reg;   // Right alternative gain code.
  logic [5:0] right_alt_gain_code_next;  // Next right code.
  logic       right_test_bit_reg;        // Read-only test bit.
  logic [5:0] left_alt_gain_code_reg;    // Left alternative gain code.
  logic [5:0] left_alt_gain_code_next;   // Next left code.
  logic       alt_gain_select_reg;       // Alternate gain select.
  logic       alt_gain_select_next;      // Next select.
  logic       eval_unlock_reg;           // Evaluation writes allowed.
  logic       eval_unlock_next;          // Next unlock.
  logic       power_keepalive_reg;       // Keepalive bit.
  logic       power_keepalive_next;      // Next keepalive.
  logic [7:0] rdata_reg;                 // Read data.
  logic [7:0] rdata_next;                // Next read data.
  logic       rvalid_reg;                // Read data valid.
  logic       seq_done;                  // Sequencer done.

  // Computes next register values from host writes and wake events.
  always_comb
  begin
    right_alt_gain_code_next = right_alt_gain_code_reg;
    left_alt_gain_code_next  = left_alt_gain_code_reg;
    alt_gain_select_next     = alt_gain_select_reg;
    eval_unlock_next         = eval_unlock_reg;
    power_keepalive_next     = power_keepalive_reg;
    if (wr_en_in)
    begin
      unique case (addr_in)
        spg_pkg::RIGHT_ALT_GAIN_ADDR:
        begin
          // Bit 7 is a test bit and is never written.
          right_alt_gain_code_next = wdata_in[spg_pkg::GAIN_MSB:0];
        end
        spg_pkg::LEFT_ALT_GAIN_ADDR:
        begin
          left_alt_gain_code_next = wdata_in[spg_pkg::GAIN_MSB:0];
          alt_gain_select_next    = wdata_in[spg_pkg::ALT_SELECT_BIT];
        end
        spg_pkg::SYSTEM_CONTROL_ADDR:
        begin
          // Revision bits are not stored.
          eval_unlock_next     = wdata_in[spg_pkg::EVAL_UNLOCK_BIT];
          power_keepalive_next = wdata_in[spg_pkg::KEEPALIVE_BIT];
        end
        default:
        begin
          // Status register and others are not written here.
        end
      endcase
    end
    // A start condition re-raises a cleared keepalive; a clear written while it is still set wins.
    if (i2c_start_in && !power_keepalive_reg)
    begin
      power_keepalive_next = 1'b1;
    end
  end

  // Computes read data for the addressed register.
  always_comb
  begin
    rdata_next = rdata_reg;
    if (rd_en_in)
    begin
      unique case (addr_in)
        spg_pkg::RIGHT_ALT_GAIN_ADDR:
        begin
          rdata_next = {right_test_bit_reg, 1'b0, right_alt_gain_code_reg};
        end
        spg_pkg::LEFT_ALT_GAIN_ADDR:
        begin
          rdata_next = {alt_gain_select_reg, 1'b0, left_alt_gain_code_reg};
        end
        spg_pkg::SYSTEM_CONTROL_ADDR:
        begin
          rdata_next = {REVISION, eval_unlock_reg, 2'b00, power_keepalive_reg};
        end
        spg_pkg::POWER_STATUS_ADDR:
        begin
          rdata_next = {1'b0,
                        status_in.brownout_flag,
                        seq_done,
                        status_in.headphone_amp_powered,
                        status_in.preamp_powered,
                        1'b0,
                        status_in.mic_pump_running,
                        status_in.mic_supply_powered};
        end
        default:
        begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  // Registers the host-visible state.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      right_alt_gain_code_reg <= spg_pkg::RIGHT_ALT_RESET[5:0];
      right_test_bit_reg      <= spg_pkg::RIGHT_ALT_RESET[spg_pkg::TEST_BIT];
      left_alt_gain_code_reg  <= spg_pkg::LEFT_ALT_RESET[5:0];
      alt_gain_select_reg     <= spg_pkg::LEFT_ALT_RESET[spg_pkg::ALT_SELECT_BIT];
      eval_unlock_reg         <= spg_pkg::EVAL_UNLOCK_RESET;
      power_keepalive_reg     <= spg_pkg::KEEPALIVE_RESET;
      rdata_reg               <= 8'h00;
      rvalid_reg              <= 1'b0;
    end
    else
    begin
      right_alt_gain_code_reg <= right_alt_gain_code_next;
      right_test_bit_reg      <= right_test_bit_reg;
      left_alt_gain_code_reg  <= left_alt_gain_code_next;
      alt_gain_select_reg     <= alt_gain_select_next;
      eval_unlock_reg         <= eval_unlock_next;
      power_keepalive_reg     <= power_keepalive_next;
      rdata_reg               <= rdata_next;
      rvalid_reg              <= rd_en_in;
    end
  end

  // ****************************************************************
  // Startup sequencer
  // ****************************************************************
  // Loads the gain set chosen by the select bit once powered.
  spg_startup_seq u_seq
  (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_in),
    .start_in      (power_keepalive_reg),
    .alt_select_in (alt_gain_select_reg),
    .alt_right_in  (right_alt_gain_code_reg),
    .alt_left_in   (left_alt_gain_code_reg),
    .pri_right_in  (pri_right_in),
    .pri_left_in   (pri_left_in),
    .gain_out      (gain_out),
    .done_out      (seq_done)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Evaluation writes pass only while unlocked.
  assign eval_wr_en_out = wr_en_in && is_eval(addr_in) && eval_unlock_reg;
  assign powered_out    = power_keepalive_reg;
  assign seq_done_out   = seq_done;
  assign rdata_out      = rdata_reg;
  assign rvalid_out     = rvalid_reg;

endmodule // spg_regs

// [spg_regs_props.sv]
`timescale 1ns/10ps
// ****************************************************************
// Port checker for the register bank.
// ****************************************************************
module spg_regs_props
(
  input  wire logic                    clock_in,       // System clock.
  input  wire logic                    rst_n_in,       // Reset, active low.
  input  wire logic                    wr_en_in,       // Write strobe.
  input  wire logic                    rd_en_in,       // Read strobe.
  input  wire logic [7:0]              addr_in,        // Register address.
  input  wire logic [7:0]              wdata_in,       // Write data.
  input  wire logic                    i2c_start_in,   // Start condition seen.
  input  wire spg_pkg::spg_block_status_t status_in,   // Live block states.
  input  wire logic [7:0]              rdata_out,      // Read data.
  input  wire logic                    rvalid_out,     // Read data valid.
  input  wire logic                    eval_wr_en_out, // Evaluation write.
  input  wire logic                    powered_out,    // Keepalive level.
  input  wire spg_pkg::spg_gain_pair_t gain_out,       // Active gain pair.
  input  wire logic                    seq_done_out    // Sequence done.
);
  logic [7:0] stat_view; // Status byte the bank should return.
  assign stat_view = {1'b0, status_in.brownout_flag, seq_done_out,
    status_in.headphone_amp_powered, status_in.preamp_powered, 1'b0,
    status_in.mic_pump_running, status_in.mic_supply_powered};
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  a_read_answer: assert property (rvalid_out == $past(rd_en_in))
    else $error("read valid not one cycle after strobe");
  a_status_bits: assert property (rd_en_in && addr_in == spg_pkg::POWER_STATUS_ADDR
    |=> rdata_out == $past(stat_view)) else $error("status byte wrong");
  a_eval_gated: assert property (eval_wr_en_out |-> wr_en_in &&
    addr_in >= spg_pkg::EVAL_FIRST_ADDR && addr_in <= spg_pkg::EVAL_LAST_ADDR)
    else $error("evaluation write outside its range");
  a_keep_drop: assert property (wr_en_in && addr_in == spg_pkg::SYSTEM_CONTROL_ADDR
    && !wdata_in[0] && !i2c_start_in |=> !powered_out) else $error("no power down");
  a_start_wake: assert property (!powered_out && i2c_start_in |=> powered_out)
    else $error("start did not wake");
  a_done_drop: assert property (!powered_out |-> ##[0:2] !seq_done_out)
    else $error("done stays while off");
  a_done_rise: assert property (powered_out [*4] |-> seq_done_out)
    else $error("sequence not done");
  a_mute_right: assert property (seq_done_out |-> gain_out.muted_right ==
    (gain_out.right_code == spg_pkg::GAIN_MUTE)) else $error("right mute wrong");
  a_mute_left: assert property (seq_done_out |-> gain_out.muted_left ==
    (gain_out.left_code == spg_pkg::GAIN_MUTE)) else $error("left mute wrong");
endmodule // spg_regs_props
bind spg_regs spg_regs_props i_props (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .i2c_start_in(i2c_start_in), .status_in(status_in), .rdata_out(rdata_out),
  .rvalid_out(rvalid_out), .eval_wr_en_out(eval_wr_en_out), .powered_out(powered_out),
  .gain_out(gain_out), .seq_done_out(seq_done_out));

// [spg_host_model.sv]
`timescale 1ns/10ps
// ****************************************************************
// Host model that issues register cycles.
// ****************************************************************
module spg_host_model
(
  input  wire logic       clock_in,  // System clock.
  input  wire logic [7:0] rdata_in,  // Read data.
  input  wire logic       rvalid_in, // Read data valid.
  output logic            wr_en_out, // Write strobe.
  output logic            rd_en_out, // Read strobe.
  output logic [7:0]      addr_out,  // Address.
  output logic [7:0]      wdata_out  // Write data.
);
  // Idle bus at time zero.
  initial
  begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out  = 8'h00;
    wdata_out = 8'h00;
  end
  // One write; the test bit of the right register is always sent as its reset 1.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    wr_en_out <= 1'b1;
    addr_out  <= a;
    wdata_out <= (a == spg_pkg::RIGHT_ALT_GAIN_ADDR) ? (d | 8'h80) : d;
    @(posedge clock_in);
    wr_en_out <= 1'b0;
  endtask
  // One read; data counts only when valid shows one cycle later.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    rd_en_out <= 1'b1;
    addr_out  <= a;
    @(posedge clock_in);
    rd_en_out <= 1'b0;
    #1;
    d = (rvalid_in === 1'b1) ? rdata_in : 8'hXX;
  endtask
endmodule // spg_host_model

// [system_power_status_alt_gain_regs_tb.sv]
`timescale 1ns/10ps
module system_power_status_alt_gain_regs_tb;
  typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} spg_row_t;
  logic clock_in = 1'b0;                   // Clock.
  logic rst_n_in = 1'b0;                   // Reset, active low.
  logic i2c_start_in = 1'b0;               // Start condition.
  logic wr_en, rd_en, rvalid, eval_wr_en;  // Bus strobes.
  logic powered, seq_done, eval_seen;      // Power and eval flags.
  logic [7:0] addr, wdata, rdata, got;     // Bus values.
  spg_pkg::spg_gain_pair_t gain;           // Active gain pair.
  spg_pkg::spg_block_status_t status = 5'h15; // Brown-out, preamp and supply on.
  int err_count = 0;                       // Mismatches.
  int checks = 0;                          // Comparisons.
  // Status 0x15 with done gives 0x69; revision 5 is an arbitrary value.
  spg_row_t rows [5] = '{'{8'h11, 8'hE5, 8'hA5}, '{8'h10, 8'h3F, 8'hBF},
    '{8'h21, 8'hFF, 8'h69}, '{8'h20, 8'hF9, 8'h59}, '{8'h55, 8'hAA, 8'h00}};
  always #4 clock_in = ~clock_in;
  spg_host_model i_host (.clock_in(clock_in), .rdata_in(rdata), .rvalid_in(rvalid),
    .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr), .wdata_out(wdata));
  spg_regs #(.REVISION(4'h5)) i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata),
    .i2c_start_in(i2c_start_in), .pri_right_in(6'h0A), .pri_left_in(6'h0B),
    .status_in(status), .rdata_out(rdata), .rvalid_out(rvalid),
    .eval_wr_en_out(eval_wr_en), .powered_out(powered), .gain_out(gain),
    .seq_done_out(seq_done));
  // Notes any cycle in which an evaluation write is let through.
  always @(negedge clock_in)
    if (wr_en === 1'b1 && eval_wr_en === 1'b1)
      eval_seen = 1'b1;
  task automatic chk(input logic [13:0] g, input logic [13:0] e, input string what);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Keepalive cleared, state seen while off, then a start condition wakes it.
  task automatic power_cycle();
    i_host.wr(8'h20, 8'h00);
    repeat (3) @(posedge clock_in);
    #1;
    chk(powered, 0, "still powered");
    chk(seq_done, 0, "done while off");
    i_host.rd(8'h21, got);
    chk(got, 8'h49, "status while off");
    @(posedge clock_in);
    i2c_start_in <= 1'b1;
    @(posedge clock_in);
    i2c_start_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    #1;
    chk({powered, seq_done}, 2'b11, "no wake");
  endtask
  initial
  begin
    #200000;
    err_count++;
    give_verdict();
  end
  initial
  begin
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'b1;
    foreach (rows[i])
    begin
      i_host.wr(rows[i].addr, rows[i].wdata);
      i_host.rd(rows[i].addr, got);
      chk(got, rows[i].exp, "row readback");
    end
    $display("test rows done");
    eval_seen = 1'b0;
    i_host.wr(8'h3E, 8'h01);
    chk(eval_seen, 1, "unlocked eval write lost");
    i_host.wr(8'h20, 8'h01);
    eval_seen = 1'b0;
    i_host.wr(8'h3F, 8'h01);
    chk(eval_seen, 0, "locked eval write passed");
    $display("test eval done");
    i_host.wr(8'h10, 8'h00);
    i_host.wr(8'h11, 8'h87);
    power_cycle();
    chk(gain, {2'b10, 6'h00, 6'h07}, "alternative pair not used");
    i_host.wr(8'h11, 8'h07);
    power_cycle();
    chk(gain, {2'b00, 6'h0A, 6'h0B}, "primary pair not used");
    $display("test gains done");
    // The other status bits are raised so every status bit except the fixed-zero bits 7 and 2 is seen high and low.
    @(posedge clock_in);
    status <= 5'h0A;
    i_host.rd(8'h21, got);
    chk(got, 8'h32, "status bits misplaced");
    $display("test status done");
    @(posedge clock_in);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'b1;
    #1;
    chk(powered, 1, "keepalive not set");
    i_host.rd(8'h10, got);
    chk(got, 8'h80, "right reset");
    i_host.rd(8'h11, got);
    chk(got, 8'h00, "left reset");
    i_host.rd(8'h20, got);
    chk(got, 8'h51, "control reset");
    $display("test reset done");
    give_verdict();
  end
endmodule // system_power_status_alt_gain_regs_tb
